/* cvmc_defs.vh */
// register map, field positions, reset values and timing for the codec control core
`ifndef CVMC_DEFS_VH
`define CVMC_DEFS_VH
// ==========================================
// register byte offsets
`define CVMC_OFS_POWER 8'h00
`define CVMC_OFS_MODE 8'h04
`define CVMC_OFS_CLOCK 8'h08
`define CVMC_OFS_MUTE 8'h0c
`define CVMC_OFS_VOL0 8'h10
`define CVMC_OFS_ATAPI 8'h28
`define CVMC_OFS_STATUS 8'h2c
`define CVMC_OFS_GPO0 8'h30
`define CVMC_OFS_LAST 8'h48
// ==========================================
// field positions
`define CVMC_MODE_SPEED 1:0
`define CVMC_MODE_ROLLOFF 2
`define CVMC_MODE_RAMP 5:4
`define CVMC_MODE_HPF_EN 6
`define CVMC_MODE_HOLD 7
`define CVMC_CLK_SWITCH 1:0
`define CVMC_CLK_PLLREF 2
`define CVMC_MUTE_CH 5:0
`define CVMC_MUTE_PIN_VAL 8
`define CVMC_MUTE_PIN_AUTO 9
`define CVMC_GPO_FUNC 1:0
`define CVMC_GPO_LEVEL 2
`define CVMC_GPO_CHAN 6:4
// ==========================================
// speed modes, gpo functions and reset values
`define CVMC_SPEED_SINGLE 2'h1
`define CVMC_SPEED_DOUBLE 2'h2
`define CVMC_SPEED_QUAD 2'h3
`define CVMC_OSR_SINGLE 8'h80
`define CVMC_OSR_DOUBLE 8'h40
`define CVMC_OSR_QUAD 8'h20
`define CVMC_GPO_DRIVE 2'h0
`define CVMC_GPO_OVFL 2'h1
`define CVMC_GPO_MUTE 2'h2
`define CVMC_RST_POWER 1'h1
`define CVMC_RST_MODE 8'h41
`define CVMC_ATTEN_MAX 8'hfe
`define CVMC_FINE_MAX 10'h3f8
`define CVMC_PLL_MULT 10'h100
// ==========================================
// timing
`define CVMC_CLK_MHZ 125
`define CVMC_PLL_LOCK_US 11000
`endif

/* cvmc_ramp.v */
// soft-ramped attenuation of one dac channel, in 0.125 dB units
`include "cvmc_defs.vh"
`default_nettype none
module cvmc_ramp (
   input wire clk_sys,
   input wire rst,
   input wire step_en,
   input wire jump,
   input wire [9:0] target,
   output reg [9:0] level_r
);
   reg [9:0] level_nxt;

   always @* begin
      level_nxt = level_r;
      if (jump) begin
         level_nxt = target;
      end else if (step_en && level_r < target) begin
         level_nxt = level_r + 10'h001;
      end else if (step_en && level_r > target) begin
         level_nxt = level_r - 10'h001;
      end
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         level_r <= `CVMC_FINE_MAX;
      end else begin
         level_r <= level_nxt;
      end
   end
endmodule // cvmc_ramp
`default_nettype wire

/* cvmc_top.v */
// codec control core: speed mode, adc limiting and offset filter, dac volume, mute, clock mux
//
// Behaviour
// [R1] single speed: up to 50 kHz, 128x oversampling
// [R2] double speed: up to 100 kHz, 64x oversampling
// [R3] quad speed: up to 192 kHz, 32x oversampling
// [R4] adc results two's complement, clipped to the largest or most negative code
// [R5] any clipped adc result sets the adc overflow status flag
// [R6] each general output pin can show adc overflow via its control register
// [R7] enabled high-pass filter tracks and subtracts dc offset; enable is independent
// [R8] offset hold freezes each channel's estimate and keeps subtracting it
// [R9] host calibrates by settling the filter, then disabling it and holding the offset
// [R10] one bit chooses fast or slow dac roll-off filter in every speed mode
// [R11] per-channel dac volume, 0 to -127 dB in 0.5 dB steps
// [R12] volume changes ramp in 0.125 dB steps at the two-bit ramp rate
// [R13] channel mute drives attenuation to -127 dB, ramping at the ramp rate
// [R14] clearing mute ramps back to the channel's volume setting
// [R15] external mute pin floats at power-up and while power-down is set
// [R16] out of power-down the pin follows host, or goes high on zero data or clock errors
// [R17] host mutes dac outputs before asserting the external mute pin
// [R18] master clock from pll or external clock, manual or automatic on lost lock
// [R19] pll reference bit locks pll to adc frame clock, output 256 times fs
// [R20] pll lock to 192 kHz completes within 11 ms
// [R21] mixing applied separately to each of the three dac channel pairs
// [R22] all configuration through one control port; host uses it for every setting
// [R23] general output pins: driven level, overflow indicator or mute output
// [R24] automatic mute on zero data needs a run of consecutive zero samples
`include "cvmc_defs.vh"
`default_nettype none
module cvmc_top #(
   parameter integer LOCK_CYCLES = `CVMC_PLL_LOCK_US * `CVMC_CLK_MHZ,
   parameter integer ZERO_SAMPLES = 1024,
   parameter integer HPF_SHIFT = 10,
   parameter integer NUM_GPO = 7
) (
   input wire clk_sys,
   input wire rst,
   input wire hsel,
   input wire [7:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   input wire adc_frame_clock,
   input wire pll_locked_in,
   input wire sclk_error_in,
   input wire adc_valid,
   input wire [51:0] adc_raw,
   output reg adc_out_valid,
   output reg [47:0] adc_out,
   input wire dac_valid,
   input wire [143:0] dac_in,
   output reg dac_out_valid,
   output reg [143:0] dac_out,
   output wire [59:0] dac_atten,
   output reg [7:0] osr_ratio,
   output reg [7:0] max_rate_khz,
   output reg rolloff_slow,
   output reg pll_enable,
   output wire [9:0] pll_multiplier,
   output reg mclk_use_external,
   output reg external_silence_pin_o,
   output reg external_silence_pin_oe,
   output reg [NUM_GPO-1:0] general_output_pins
);
   // ==========================================
   // registers and bus state
   reg power_r;
   reg [7:0] mode_r;
   reg [2:0] clock_r;
   reg [9:0] mute_r;
   reg [47:0] vol_r;
   reg [11:0] atapi_r;
   reg [7*NUM_GPO-1:0] gpo_r;
   reg ovfl_r;
   reg timeout_r;
   reg wr_pend_r;
   reg [7:0] wr_addr_r;
   reg [2:0] sync1_r;
   reg [2:0] sync2_r;
   reg frame_prev_r;
   reg [1:0] rate_cnt_r;
   reg [20:0] lock_cnt_r;
   reg [10:0] zero_cnt_r;
   wire [47:0] res;
   wire addr_phase;
   wire frame_tick;
   wire pll_locked;
   wire sclk_err;
   wire ramp_step;
   wire zero_frame;
   wire zero_run;
   wire [1:0] clip;
   integer i, j, k, m;

   // every byte offset lies on a word; volume and gpo decode only address bits 6:2, so their aliases respond; other unmapped reads give zero, writes are dropped
   function [4:0] reg_index;
      input [7:0] a;
      begin
         reg_index = a[6:2];
      end
   endfunction

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign pll_multiplier = `CVMC_PLL_MULT; // R19
   assign addr_phase = hsel && htrans[1] && hready; // R22

   // ==========================================
   // input synchronisers
   always @(posedge clk_sys) begin
      if (rst) begin
         sync1_r <= 3'h0;
         sync2_r <= 3'h0;
         frame_prev_r <= 1'b0;
      end else begin
         sync1_r <= {sclk_error_in, pll_locked_in, adc_frame_clock};
         sync2_r <= sync1_r;
         frame_prev_r <= sync2_r[0];
      end
   end
   assign frame_tick = sync2_r[0] && !frame_prev_r;
   assign pll_locked = sync2_r[1];
   assign sclk_err = sync2_r[2];

   // ==========================================
   // register writes
   always @(posedge clk_sys) begin
      if (rst) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         power_r <= `CVMC_RST_POWER; // R15
         mode_r <= `CVMC_RST_MODE;
         clock_r <= 3'h0;
         mute_r <= 10'h000;
         vol_r <= 48'h0000_0000_0000;
         atapi_r <= 12'h999;
         gpo_r <= {(7*NUM_GPO){1'b0}};
      end else begin
         wr_pend_r <= addr_phase && hwrite;
         wr_addr_r <= haddr;
         if (wr_pend_r) begin
            case (wr_addr_r)
               `CVMC_OFS_POWER: power_r <= hwdata[0];
               `CVMC_OFS_MODE: mode_r <= hwdata[7:0];
               `CVMC_OFS_CLOCK: clock_r <= hwdata[2:0];
               `CVMC_OFS_MUTE: mute_r <= hwdata[9:0];
               `CVMC_OFS_ATAPI: atapi_r <= hwdata[11:0];
               default: begin
                  for (i = 0; i < 6; i = i + 1) begin
                     if (reg_index(wr_addr_r) == reg_index(`CVMC_OFS_VOL0) + i) begin
                        vol_r[8*i +: 8] <= (hwdata[7:0] > `CVMC_ATTEN_MAX) ?
                           `CVMC_ATTEN_MAX : hwdata[7:0]; // R11
                     end
                  end
                  for (i = 0; i < NUM_GPO; i = i + 1) begin
                     if (reg_index(wr_addr_r) == reg_index(`CVMC_OFS_GPO0) + i) begin
                        gpo_r[7*i +: 7] <= hwdata[6:0];
                     end
                  end
               end
            endcase
         end
      end
   end

   // ==========================================
   // register reads, captured in the address phase
   always @(posedge clk_sys) begin
      if (rst) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         hrdata <= 32'h0000_0000;
         case (haddr)
            `CVMC_OFS_POWER: hrdata[0] <= power_r;
            `CVMC_OFS_MODE: hrdata[7:0] <= mode_r;
            `CVMC_OFS_CLOCK: hrdata[2:0] <= clock_r;
            `CVMC_OFS_MUTE: hrdata[9:0] <= mute_r;
            `CVMC_OFS_ATAPI: hrdata[11:0] <= atapi_r;
            `CVMC_OFS_STATUS: hrdata[4:0] <= {external_silence_pin_o, timeout_r,
               mclk_use_external, pll_locked, ovfl_r};
            default: begin
               for (j = 0; j < 6; j = j + 1) begin
                  if (reg_index(haddr) == reg_index(`CVMC_OFS_VOL0) + j) begin
                     hrdata[7:0] <= vol_r[8*j +: 8];
                  end
               end
               for (j = 0; j < NUM_GPO; j = j + 1) begin
                  if (reg_index(haddr) == reg_index(`CVMC_OFS_GPO0) + j) begin
                     hrdata[6:0] <= gpo_r[7*j +: 7];
                  end
               end
            end
         endcase
      end
   end

   // ==========================================
   // speed mode and filter select
   always @(posedge clk_sys) begin
      if (rst) begin
         osr_ratio <= `CVMC_OSR_SINGLE;
         max_rate_khz <= 8'd50;
         rolloff_slow <= 1'b0;
      end else begin
         rolloff_slow <= mode_r[`CVMC_MODE_ROLLOFF]; // R10
         case (mode_r[`CVMC_MODE_SPEED])
            `CVMC_SPEED_DOUBLE: begin
               osr_ratio <= `CVMC_OSR_DOUBLE; // R2
               max_rate_khz <= 8'd100;
            end
            `CVMC_SPEED_QUAD: begin
               osr_ratio <= `CVMC_OSR_QUAD; // R3
               max_rate_khz <= 8'd192;
            end
            default: begin
               osr_ratio <= `CVMC_OSR_SINGLE; // R1
               max_rate_khz <= 8'd50;
            end
         endcase
      end
   end

   // ==========================================
   // adc offset filter and limiting
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_adc
         reg signed [25:0] est_r;
         wire signed [25:0] x = adc_raw[26*g +: 26];
         wire signed [26:0] err = x - est_r;
         wire signed [26:0] upd = est_r + (err >>> HPF_SHIFT);
         wire use_est = mode_r[`CVMC_MODE_HPF_EN] || mode_r[`CVMC_MODE_HOLD]; // R8
         wire signed [26:0] d = use_est ? err : {x[25], x}; // R7
         assign clip[g] = (d > 27'sd8388607) || (d < -27'sd8388608);
         assign res[24*g +: 24] = (d > 27'sd8388607) ? 24'h7f_ffff :
            (d < -27'sd8388608) ? 24'h80_0000 : d[23:0]; // R4
         always @(posedge clk_sys) begin
            if (rst) begin
               est_r <= 26'sd0;
            end else if (adc_valid && mode_r[`CVMC_MODE_HPF_EN] && !mode_r[`CVMC_MODE_HOLD]) begin
               est_r <= upd[25:0]; // R7
            end
         end
      end
   endgenerate

   always @(posedge clk_sys) begin
      if (rst) begin
         adc_out_valid <= 1'b0;
         adc_out <= 48'h0000_0000_0000;
         ovfl_r <= 1'b0;
      end else begin
         adc_out_valid <= adc_valid;
         if (adc_valid) begin
            adc_out <= res; // R4
         end
         if (adc_valid && |clip) begin
            ovfl_r <= 1'b1; // R5
         end else if (addr_phase && !hwrite && haddr == `CVMC_OFS_STATUS) begin
            ovfl_r <= 1'b0;
         end
      end
   end

   // ==========================================
   // pair mixing
   function [23:0] mix;
      input [1:0] sel;
      input [23:0] l;
      input [23:0] r;
      reg [24:0] s;
      begin
         s = {l[23], l} + {r[23], r};
         case (sel)
            2'h1: mix = l;
            2'h2: mix = r;
            2'h3: mix = s[24:1];
            default: mix = 24'h00_0000;
         endcase
      end
   endfunction

   assign zero_frame = (dac_in == 144'h0);
   assign zero_run = (zero_cnt_r == ZERO_SAMPLES[10:0]);

   always @(posedge clk_sys) begin
      if (rst) begin
         dac_out_valid <= 1'b0;
         dac_out <= 144'h0;
         zero_cnt_r <= 11'h000;
      end else begin
         dac_out_valid <= dac_valid;
         if (dac_valid) begin
            for (k = 0; k < 3; k = k + 1) begin
               dac_out[48*k +: 24] <= mix(atapi_r[4*k +: 2], dac_in[48*k +: 24],
                  dac_in[48*k+24 +: 24]); // R21
               dac_out[48*k+24 +: 24] <= mix(atapi_r[4*k+2 +: 2], dac_in[48*k +: 24],
                  dac_in[48*k+24 +: 24]); // R21
            end
            if (!zero_frame) begin
               zero_cnt_r <= 11'h000;
            end else if (!zero_run) begin
               zero_cnt_r <= zero_cnt_r + 11'h001; // R24
            end
         end
      end
   end

   // ==========================================
   // volume ramp, one step per ramp period of frames
   assign ramp_step = frame_tick && (mode_r[5:4] == 2'h1 ||
      (mode_r[5:4] == 2'h2 && rate_cnt_r[0]) || (mode_r[5:4] == 2'h3 && &rate_cnt_r)); // R12

   always @(posedge clk_sys) begin
      if (rst) begin
         rate_cnt_r <= 2'h0;
      end else if (frame_tick) begin
         rate_cnt_r <= rate_cnt_r + 2'h1;
      end
   end

   generate
      for (g = 0; g < 6; g = g + 1) begin : g_vol
         cvmc_ramp u_ramp (
            .clk_sys(clk_sys),
            .rst(rst),
            .step_en(ramp_step),
            .jump(mode_r[`CVMC_MODE_RAMP] == 2'h0),
            .target(mute_r[g] ? `CVMC_FINE_MAX : {vol_r[8*g +: 8], 2'b00}), // R13 R14
            .level_r(dac_atten[10*g +: 10])
         );
      end
   endgenerate

   // ==========================================
   // external mute pin and general outputs
   always @(posedge clk_sys) begin
      if (rst) begin
         external_silence_pin_o <= 1'b0;
         external_silence_pin_oe <= 1'b0; // R15
         general_output_pins <= {NUM_GPO{1'b0}};
      end else begin
         external_silence_pin_oe <= !power_r; // R15
         if (mute_r[`CVMC_MUTE_PIN_AUTO]) begin
            external_silence_pin_o <= zero_run || sclk_err; // R16
         end else begin
            external_silence_pin_o <= mute_r[`CVMC_MUTE_PIN_VAL]; // R16
         end
         for (m = 0; m < NUM_GPO; m = m + 1) begin
            case (gpo_r[7*m +: 2])
               `CVMC_GPO_OVFL: general_output_pins[m] <= ovfl_r; // R6 R23
               `CVMC_GPO_MUTE: general_output_pins[m] <=
                  mute_r[(gpo_r[7*m+4 +: 3] > 3'h5) ? 3'h5 : gpo_r[7*m+4 +: 3]]; // R23
               default: general_output_pins[m] <= gpo_r[7*m+2]; // R23
            endcase
         end
      end
   end

   // ==========================================
   // master clock source selection and lock watch
   always @(posedge clk_sys) begin
      if (rst) begin
         pll_enable <= 1'b0;
         mclk_use_external <= 1'b0;
         lock_cnt_r <= 21'h00_0000;
         timeout_r <= 1'b0;
      end else begin
         pll_enable <= clock_r[`CVMC_CLK_PLLREF]; // R19
         if (!clock_r[1]) begin
            mclk_use_external <= clock_r[0]; // R18
         end else if (mclk_use_external != clock_r[0]) begin
            mclk_use_external <= !pll_locked ? 1'b1 : clock_r[0]; // R18
         end else if (!clock_r[0] && !pll_locked) begin
            mclk_use_external <= 1'b1; // R18
         end
         if (!clock_r[`CVMC_CLK_PLLREF] || pll_locked) begin
            lock_cnt_r <= 21'h00_0000;
            timeout_r <= 1'b0;
         end else if (lock_cnt_r == LOCK_CYCLES[20:0]) begin
            timeout_r <= 1'b1; // R20
         end else begin
            lock_cnt_r <= lock_cnt_r + 21'h00_0001; // R20
         end
      end
   end
endmodule // cvmc_top
`default_nettype wire

/* cvmc_chk_sva.sv */
// checker: bus, latency, output map and pin assertions for the codec control core
`include "cvmc_defs.vh"
`default_nettype none
module cvmc_chk (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic adc_valid,
   input wire logic adc_out_valid,
   input wire logic dac_valid,
   input wire logic dac_out_valid,
   input wire logic [59:0] dac_atten,
   input wire logic [7:0] osr_ratio,
   input wire logic [7:0] max_rate_khz,
   input wire logic [9:0] pll_multiplier,
   input wire logic mclk_use_external,
   input wire logic external_silence_pin_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic pw_r;
   logic ck_r;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ==========================================
   // data-phase markers for power and clock writes
   always @(posedge clk_sys) begin
      pw_r <= hsel && htrans[1] && hready && hwrite && haddr == `CVMC_OFS_POWER;
      ck_r <= hsel && htrans[1] && hready && hwrite && haddr == `CVMC_OFS_CLOCK;
   end
   function automatic logic at_ok(logic [59:0] a);
      at_ok = 1'b1;
      for (int i = 0; i < 6; i++) if (a[i*10+:10] > `CVMC_FINE_MAX) at_ok = 1'b0;
   endfunction
   // ==========================================
   // assertions
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus response not okay");
   adc_lat_a: assert property (adc_out_valid == $past(adc_valid))
      else $error("adc result latency wrong");
   dac_lat_a: assert property (dac_out_valid == $past(dac_valid))
      else $error("dac output latency wrong");
   speed_single_a: assert property (osr_ratio == `CVMC_OSR_SINGLE |-> max_rate_khz == 8'h32)
      else $error("single speed map wrong");
   speed_double_a: assert property (osr_ratio == `CVMC_OSR_DOUBLE |-> max_rate_khz == 8'h64)
      else $error("double speed map wrong");
   speed_quad_a: assert property (osr_ratio == `CVMC_OSR_QUAD |-> max_rate_khz == 8'hc0)
      else $error("quad speed map wrong");
   pll_mult_a: assert property (pll_multiplier == `CVMC_PLL_MULT)
      else $error("pll multiplier wrong");
   atten_range_a: assert property (at_ok(dac_atten))
      else $error("attenuation out of range");
   pdn_float_a: assert property (pw_r && hwdata[0] |-> ##[1:2] !external_silence_pin_oe)
      else $error("mute pin driven in power-down");
   clk_ext_a: assert property (ck_r && hwdata[1:0] == 2'h1 |-> ##[1:4] mclk_use_external)
      else $error("manual external clock not taken");
   clk_pll_a: assert property (ck_r && hwdata[1:0] == 2'h0 |-> ##[1:4] !mclk_use_external)
      else $error("manual pll clock not taken");
   cover property (pw_r && hwdata[0]);
   cover property (adc_valid ##1 adc_out_valid);
   cover property (ck_r && hwdata[1]);
endmodule // cvmc_chk
bind cvmc_top cvmc_chk u_chk (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .adc_valid(adc_valid), .adc_out_valid(adc_out_valid), .dac_valid(dac_valid),
   .dac_out_valid(dac_out_valid), .dac_atten(dac_atten), .osr_ratio(osr_ratio),
   .max_rate_khz(max_rate_khz), .pll_multiplier(pll_multiplier),
   .mclk_use_external(mclk_use_external), .external_silence_pin_oe(external_silence_pin_oe));
`default_nettype wire

/* cvmc_src_model.sv */
// frame clock source and pll lock model beside the codec control core
`default_nettype none
module cvmc_src_model #(
   parameter int LOCK_EDGES = 8
) (
   input wire logic run,
   input wire logic lock_ok,
   output logic frame_clk,
   output logic locked
);
   timeunit 1ns;
   timeprecision 100ps;
   int edges;
   initial begin
      frame_clk = 1'b0;
      locked = 1'b0;
      edges = 0;
   end
   // frame clock stands low while not running
   always begin
      #62.5;
      frame_clk = run ? ~frame_clk : 1'b0;
   end
   // lock follows a run of frame edges, lost at once
   always @(posedge frame_clk or negedge lock_ok) begin
      if (!lock_ok) begin
         edges = 0;
         locked = 1'b0;
      end else if (edges >= LOCK_EDGES) locked = 1'b1;
      else edges++;
   end
endmodule // cvmc_src_model
`default_nettype wire

/* tb_codec_volume_mute_clock_ctl.sv */
// self-checking bench for the codec control core
`include "cvmc_defs.vh"
`default_nettype none
module tb_codec_volume_mute_clock_ctl;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 0, rst = 1, hsel = 0, hwrite = 0, adc_valid = 0, dac_valid = 0;
   logic sclk_error_in = 0, lock_ok = 0;
   logic [7:0] haddr = 0;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 0;
   logic [31:0] hwdata = 0, rdv;
   logic [51:0] adc_raw = 0;
   logic [143:0] dac_in = 0;
   logic [143:0] dv = {{2{24'h00_0055}}, {2{24'h00_0030, 24'h00_0010}}};
   logic [7:0] osr_t [4] = '{`CVMC_OSR_SINGLE, `CVMC_OSR_SINGLE, `CVMC_OSR_DOUBLE, `CVMC_OSR_QUAD};
   logic [7:0] rate_t [4] = '{8'h32, 8'h32, 8'h64, 8'hc0};
   wire hreadyout, hresp, adc_out_valid, dac_out_valid, rolloff_slow, pll_enable, mclk;
   wire pin_o, pin_oe, frame, locked;
   wire [31:0] hrdata;
   wire [47:0] adc_out;
   wire [143:0] dac_out;
   wire [59:0] atn;
   wire [7:0] osr_ratio, max_rate_khz;
   wire [9:0] pll_mult;
   wire [6:0] gpo;
   int bad_count = 0, total_checks = 0, n;
   always #4 clk_sys = ~clk_sys;
   cvmc_top #(.LOCK_CYCLES(200), .ZERO_SAMPLES(4), .HPF_SHIFT(2)) DUT (
      .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .adc_frame_clock(frame),
      .pll_locked_in(locked), .sclk_error_in(sclk_error_in), .adc_valid(adc_valid),
      .adc_raw(adc_raw), .adc_out_valid(adc_out_valid), .adc_out(adc_out),
      .dac_valid(dac_valid), .dac_in(dac_in), .dac_out_valid(dac_out_valid), .dac_out(dac_out),
      .dac_atten(atn), .osr_ratio(osr_ratio), .max_rate_khz(max_rate_khz),
      .rolloff_slow(rolloff_slow), .pll_enable(pll_enable), .pll_multiplier(pll_mult),
      .mclk_use_external(mclk), .external_silence_pin_o(pin_o),
      .external_silence_pin_oe(pin_oe), .general_output_pins(gpo));
   cvmc_src_model u_src (.run(1'b1), .lock_ok(lock_ok), .frame_clk(frame),
      .locked(locked));
   // ==========================================
   // tasks
   task automatic chk(string nm, logic [143:0] s, logic [143:0] e);
      total_checks++;
      if (s !== e) begin
         bad_count++;
         $display("wrong value %s expected %0h seen %0h", nm, e, s);
      end
   endtask
   task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      rdv = hrdata;
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(logic [7:0] a);
      bus(1'b0, a, 32'h0000_0000);
   endtask
   task automatic wt(int c);
      repeat (c) @(posedge clk_sys);
   endtask
   task automatic adc(logic [51:0] r);
      @(posedge clk_sys);
      adc_valid <= 1;
      adc_raw <= r;
      @(posedge clk_sys);
      adc_valid <= 0;
      @(negedge clk_sys);
   endtask
   task automatic dac(logic [143:0] d);
      @(posedge clk_sys);
      dac_valid <= 1;
      dac_in <= d;
      @(posedge clk_sys);
      dac_valid <= 0;
      @(negedge clk_sys);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #300us;
      bad_count++;
      print_verdict;
   end
   // ==========================================
   // tests
   initial begin
      wt(3);
      chk("atten", atn, {6{`CVMC_FINE_MAX}});
      rst <= 0;
      rd(`CVMC_OFS_POWER);
      chk("power", rdv, `CVMC_RST_POWER);
      rd(`CVMC_OFS_MODE);
      chk("mode", rdv, `CVMC_RST_MODE);
      chk("pin oe", pin_oe, 1'b0);
      wr(8'hfc, 32'hffff_ffff);
      rd(8'hfc);
      chk("unmapped", rdv, 32'h0000_0000);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         wr(`CVMC_OFS_MODE, {29'h0, i[0], i[1:0]});
         wt(2);
         chk("osr", osr_ratio, osr_t[i]);
         chk("rate", max_rate_khz, rate_t[i]);
         chk("rolloff", rolloff_slow, i[0]);
      end
      $display("test speed done");
      wr(`CVMC_OFS_MODE, 32'h0000_0001);
      wr(`CVMC_OFS_GPO0, 32'h0000_0001);
      wr(`CVMC_OFS_GPO0 + 8'h04, 32'h0000_0004);
      adc({26'h37f_ffff, 26'h080_0000});
      chk("clip", adc_out, 48'h8000_007f_ffff);
      wt(2);
      chk("ovfl pin", gpo[0], 1'b1);
      chk("drive pin", gpo[1], 1'b1);
      rd(`CVMC_OFS_STATUS);
      chk("ovfl", rdv[0], 1'b1);
      rd(`CVMC_OFS_STATUS);
      chk("ovfl clear", rdv[0], 1'b0);
      adc({26'h3ff_ffff, 26'h000_0123});
      chk("adc", adc_out, 48'hffff_ff00_0123);
      wr(`CVMC_OFS_MODE, 32'h0000_0041);
      repeat (60) adc({26'h000_0000, 26'h001_0000});
      chk("hpf", adc_out[23:0] < 24'h0100, 1'b1);
      wr(`CVMC_OFS_MODE, 32'h0000_00c1);
      adc(52'h0_0000_0000_0000);
      chk("hold", adc_out[23], 1'b1);
      wr(`CVMC_OFS_MODE, 32'h0000_0081);
      adc({26'h000_0000, 26'h001_0000});
      chk("calib", adc_out[23:0] < 24'h0100, 1'b1);
      wr(`CVMC_OFS_MODE, 32'h0000_0001);
      adc({26'h000_0000, 26'h001_0000});
      chk("hpf off", adc_out[23:0], 24'h01_0000);
      $display("test adc done");
      wr(`CVMC_OFS_VOL0 + 8'h04, 32'h0000_0004);
      wt(2);
      chk("vol", atn[19:10], 10'h010);
      wr(`CVMC_OFS_VOL0 + 8'h08, 32'h0000_00ff);
      wt(2);
      chk("clamp", atn[29:20], `CVMC_FINE_MAX);
      wr(`CVMC_OFS_MUTE, 32'h0000_0002);
      wt(2);
      chk("mute", atn[19:10], `CVMC_FINE_MAX);
      wr(`CVMC_OFS_MUTE, 32'h0000_0000);
      wt(2);
      chk("unmute", atn[19:10], 10'h010);
      wr(`CVMC_OFS_VOL0, 32'h0000_000a);
      wr(`CVMC_OFS_MODE, 32'h0000_0011);
      wr(`CVMC_OFS_VOL0, 32'h0000_0000);
      for (n = 0; n < 100 && atn[9:0] === 10'h028; n++) @(posedge clk_sys);
      chk("ramp step", atn[9:0], 10'h027);
      wt(1000);
      chk("ramp end", atn[9:0], 10'h000);
      wr(`CVMC_OFS_MUTE, 32'h0000_0001);
      wt(100);
      chk("mute ramp", atn[9:0] > 0 && atn[9:0] < `CVMC_FINE_MAX, 1'b1);
      $display("test volume done");
      dac(dv);
      chk("mix pass", dac_out, dv);
      wr(`CVMC_OFS_ATAPI, 32'h0000_0936);
      dac(dv);
      chk("mix", dac_out, {{2{24'h00_0055}}, 48'h0000_0000_0020, 48'h0000_1000_0030});
      $display("test mixing done");
      wr(`CVMC_OFS_POWER, 32'h0000_0000);
      wr(`CVMC_OFS_MUTE, 32'h0000_003f);
      wr(`CVMC_OFS_GPO0 + 8'h08, 32'h0000_0002);
      wt(2);
      chk("gpo mute", gpo[2], 1'b1);
      wr(`CVMC_OFS_MUTE, 32'h0000_013f);
      wt(2);
      chk("pin oe", pin_oe, 1'b1);
      chk("pin host", pin_o, 1'b1);
      wr(`CVMC_OFS_MUTE, 32'h0000_023f);
      wt(2);
      chk("pin auto", pin_o, 1'b0);
      sclk_error_in <= 1;
      wt(8);
      chk("clock error", pin_o, 1'b1);
      sclk_error_in <= 0;
      wt(8);
      repeat (2) dac(144'h0);
      chk("zero short", pin_o, 1'b0);
      repeat (4) dac(144'h0);
      wt(2);
      chk("zero run", pin_o, 1'b1);
      wr(`CVMC_OFS_POWER, 32'h0000_0001);
      wt(2);
      chk("pin float", pin_oe, 1'b0);
      $display("test mute pin done");
      wr(`CVMC_OFS_CLOCK, 32'h0000_0001);
      wt(4);
      chk("ext clock", mclk, 1'b1);
      wr(`CVMC_OFS_CLOCK, 32'h0000_0000);
      wt(4);
      chk("pll clock", mclk, 1'b0);
      wr(`CVMC_OFS_CLOCK, 32'h0000_0006);
      wt(4);
      chk("pll enable", pll_enable, 1'b1);
      chk("pll mult", pll_mult, `CVMC_PLL_MULT);
      chk("auto ext", mclk, 1'b1);
      wt(250);
      rd(`CVMC_OFS_STATUS);
      chk("lock timeout", rdv[3], 1'b1);
      lock_ok <= 1;
      wt(300);
      rd(`CVMC_OFS_STATUS);
      chk("locked", rdv[1], 1'b1);
      chk("auto pll", mclk, 1'b0);
      $display("test clock done");
      print_verdict;
   end
endmodule // tb_codec_volume_mute_clock_ctl
`default_nettype wire
